// >>> sac_pkg.sv
// constants and types shared by the converter control block
package sac_pkg;
  // conversion clock limit and derived divider
  localparam int CLK_KHZ = 40000;
  localparam int SAR_MAX_KHZ = 3000;
  localparam int SAR_DIV = (CLK_KHZ + SAR_MAX_KHZ - 1) / SAR_MAX_KHZ;
  // phase lengths in conversion clock periods
  localparam int TRACK_SAR = 3;
  localparam int CONV_SAR = 10;
  localparam int RES_W = 10;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_NEG = 8'hba;
  localparam logic [7:0] IDX_CFG = 8'hbc;
  localparam logic [7:0] IDX_RES_LO = 8'hbd;
  localparam logic [7:0] IDX_RES_HI = 8'hbe;
  localparam logic [7:0] IDX_ABV_LO = 8'hc3;
  localparam logic [7:0] IDX_ABV_HI = 8'hc4;
  localparam logic [7:0] IDX_BLW_LO = 8'hc5;
  localparam logic [7:0] IDX_BLW_HI = 8'hc6;
  localparam logic [7:0] IDX_CTRL = 8'he8;
  // control register fields
  localparam int CTRL_EN = 7;
  localparam int CTRL_TM = 6;
  localparam int CTRL_DONE = 5;
  localparam int CTRL_BUSY = 4;
  localparam int CTRL_WIN = 3;
  localparam int CTRL_CM_MSB = 2;
  localparam int CTRL_CM_LSB = 0;
  localparam int CFG_LJST = 2;
  localparam int NEG_W = 5;
  // start source codes
  localparam logic [2:0] CM_SW = 3'h0;
  localparam logic [2:0] CM_T0 = 3'h1;
  localparam logic [2:0] CM_T2 = 3'h2;
  localparam logic [2:0] CM_T1 = 3'h3;
  localparam logic [2:0] CM_EXT = 3'h4;
  localparam logic [2:0] CM_T3 = 3'h5;
  // negative input code that selects ground
  localparam logic [4:0] NEG_GND = 5'h1f;
  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] CM_RST = 3'h0;
  localparam logic [4:0] NEG_RST = 5'h00;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV = 2'b11,
    ST_DONE = 2'b10
  } sac_state_t;
endpackage

// >>> sac_tick.sv
// conversion clock tick generator
`timescale 1ns/100ps
module sac_tick #(
  parameter int DIV = 14
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam int W = $clog2(DIV + 1);
  logic [W-1:0] cnt_r;

  // restarts from zero whenever run drops
  assign tick_o = run_i && (cnt_r == W'(DIV - 1));

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || !run_i) begin
      cnt_r <= '0;
    end else if (tick_o) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end
endmodule

// >>> sac_top.sv
// converter control, result formatting and window detector
`timescale 1ns/100ps
module sac_top import sac_pkg::*; #(
  parameter int DIV = SAR_DIV
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic timer0_ovf_i,
  input wire logic timer1_ovf_i,
  input wire logic timer2_ovf_i,
  input wire logic timer3_ovf_i,
  input wire logic external_start_input_i,
  input wire logic [RES_W-1:0] sar_data_i,
  output logic converter_power_o,
  output logic track_o,
  output logic convert_o
);
  sac_state_t state_r, state_nxt;
  logic wait_r;
  logic [31:0] rdata_r;
  logic [7:0] rd_mux;
  logic [7:0] idx;
  logic [7:0] wd;
  logic acc_wr;
  logic wr_ctrl;
  logic converter_enable_r, track_mode_select_r;
  logic [2:0] start_source_select_r;
  logic conversion_done_flag_r, conversion_busy_bit_r;
  logic window_match_flag_r;
  logic justify_left_select_r;
  logic [NEG_W-1:0] negative_input_select_r;
  logic [7:0] above_threshold_low_r, above_threshold_high_r;
  logic [7:0] below_threshold_low_r, below_threshold_high_r;
  logic [7:0] result_low_byte_r, result_high_byte_r;
  logic [RES_W-1:0] res_r;
  logic [3:0] sar_cnt_r;
  logic ext_d_r;
  logic ext_rise, hw_trig, sw_go, start, mode_lp, direct;
  logic tick, cap, done_set, match, diff;
  logic [15:0] cmp_word, abv_word, blw_word;
  logic track_r, conv_r;

  assign idx = avs_address_i[9:2];
  assign wd = avs_writedata_i[7:0];
  assign acc_wr = avs_write_i && !wait_r && avs_byteenable_i[0];
  assign wr_ctrl = acc_wr && (idx == IDX_CTRL);

  // bus slave: one wait cycle, then answer
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      wait_r <= 1'b1;
    end else if (!wait_r) begin
      wait_r <= 1'b1;
    end else if (avs_read_i || avs_write_i) begin
      wait_r <= 1'b0;
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (idx)
      IDX_NEG: rd_mux = {3'h0, negative_input_select_r};
      IDX_CFG: rd_mux = {5'h00, justify_left_select_r, 2'h0};
      IDX_RES_LO: rd_mux = result_low_byte_r;
      IDX_RES_HI: rd_mux = result_high_byte_r;
      IDX_ABV_LO: rd_mux = above_threshold_low_r;
      IDX_ABV_HI: rd_mux = above_threshold_high_r;
      IDX_BLW_LO: rd_mux = below_threshold_low_r;
      IDX_BLW_HI: rd_mux = below_threshold_high_r;
      IDX_CTRL: rd_mux = {converter_enable_r, track_mode_select_r,
                          conversion_done_flag_r,
                          conversion_busy_bit_r,
                          window_match_flag_r, start_source_select_r};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i && wait_r) begin
      rdata_r <= {24'h00_0000, rd_mux};
    end
  end

  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

  // configuration and limit registers
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      justify_left_select_r <= 1'b0;
      negative_input_select_r <= NEG_RST;
      above_threshold_low_r <= BYTE_RST;
      above_threshold_high_r <= BYTE_RST;
      below_threshold_low_r <= BYTE_RST;
      below_threshold_high_r <= BYTE_RST;
    end else if (acc_wr) begin
      unique case (idx)
        IDX_CFG: justify_left_select_r <= wd[CFG_LJST];
        IDX_NEG: negative_input_select_r <= wd[NEG_W-1:0];
        IDX_ABV_LO: above_threshold_low_r <= wd;
        IDX_ABV_HI: above_threshold_high_r <= wd;
        IDX_BLW_LO: below_threshold_low_r <= wd;
        IDX_BLW_HI: below_threshold_high_r <= wd;
        default: ;
      endcase
    end
  end

  // control settings
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      converter_enable_r <= 1'b0;
      track_mode_select_r <= 1'b0;
      start_source_select_r <= CM_RST;
    end else if (wr_ctrl) begin
      converter_enable_r <= wd[CTRL_EN];
      track_mode_select_r <= wd[CTRL_TM];
      start_source_select_r <= wd[CTRL_CM_MSB:CTRL_CM_LSB];
    end
  end

  // trigger selection
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      ext_d_r <= 1'b0;
    end else begin
      ext_d_r <= external_start_input_i;
    end
  end

  assign ext_rise = external_start_input_i && !ext_d_r;

  always_comb begin
    hw_trig = 1'b0;
    unique case (start_source_select_r)
      CM_T0: hw_trig = timer0_ovf_i;
      CM_T2: hw_trig = timer2_ovf_i;
      CM_T1: hw_trig = timer1_ovf_i;
      CM_EXT: hw_trig = ext_rise;
      CM_T3: hw_trig = timer3_ovf_i;
      default: hw_trig = 1'b0;
    endcase
  end

  // a write of zero to busy starts nothing
  assign sw_go = wr_ctrl && wd[CTRL_BUSY] && wd[CTRL_EN] &&
                 (wd[CTRL_CM_MSB:CTRL_CM_LSB] == CM_SW);
  assign start = (state_r == ST_IDLE) &&
                 (sw_go || (converter_enable_r && hw_trig));
  assign mode_lp = sw_go ? wd[CTRL_TM] : track_mode_select_r;
  assign direct = !mode_lp ||
                  (!sw_go && start_source_select_r == CM_EXT);

  sac_tick #(.DIV(DIV)) u_tick (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .run_i(state_r == ST_TRACK || state_r == ST_CONV),
    .tick_o(tick)
  );

  // sequencer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (start) begin
          state_nxt = direct ? ST_CONV : ST_TRACK;
        end
      end
      ST_TRACK: begin
        if (!converter_enable_r) begin
          state_nxt = ST_IDLE;
        end else if (tick && sar_cnt_r == 4'(TRACK_SAR - 1)) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (!converter_enable_r) begin
          state_nxt = ST_IDLE;
        end else if (tick && sar_cnt_r == 4'(CONV_SAR - 1)) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i || state_nxt != state_r) begin
      sar_cnt_r <= 4'h0;
    end else if (tick) begin
      sar_cnt_r <= sar_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      conversion_busy_bit_r <= 1'b0;
    end else if (start) begin
      conversion_busy_bit_r <= 1'b1;
    end else if (state_r != ST_IDLE && state_nxt == ST_IDLE) begin
      conversion_busy_bit_r <= 1'b0;
    end
  end

  // result capture and formatting
  assign cap = (state_r == ST_CONV) && (state_nxt == ST_DONE);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      res_r <= '0;
      result_low_byte_r <= BYTE_RST;
      result_high_byte_r <= BYTE_RST;
    end else if (cap) begin
      res_r <= sar_data_i;
      if (justify_left_select_r) begin
        result_high_byte_r <= sar_data_i[9:2];
        result_low_byte_r <= {sar_data_i[1:0], 6'h00};
      end else begin
        result_high_byte_r <= {{6{sar_data_i[9]}},
                               sar_data_i[9:8]};
        result_low_byte_r <= sar_data_i[7:0];
      end
    end else if (acc_wr && idx == IDX_RES_LO) begin
      result_low_byte_r <= wd;
    end else if (acc_wr && idx == IDX_RES_HI) begin
      result_high_byte_r <= wd;
    end
  end

  // window detector on the captured result
  assign diff = negative_input_select_r != NEG_GND;
  always_comb begin
    if (justify_left_select_r) begin
      cmp_word = {res_r, 6'h00};
    end else if (diff) begin
      cmp_word = {{6{res_r[9]}}, res_r};
    end else begin
      cmp_word = {6'h00, res_r};
    end
  end

  // limits are taken in the format now configured
  // flipping the top bit turns a signed compare into unsigned
  assign abv_word = {above_threshold_high_r, above_threshold_low_r} ^
                    {diff, 15'h0000};
  assign blw_word = {below_threshold_high_r, below_threshold_low_r} ^
                    {diff, 15'h0000};

  always_comb begin
    logic gt_ok;
    logic lt_ok;
    gt_ok = (cmp_word ^ {diff, 15'h0000}) > abv_word;
    lt_ok = (cmp_word ^ {diff, 15'h0000}) < blw_word;
    if (blw_word > abv_word) begin
      match = gt_ok && lt_ok;
    end else begin
      match = gt_ok || lt_ok;
    end
  end

  // sticky flags, hardware set wins over a clearing write
  assign done_set = (state_r == ST_DONE);

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      conversion_done_flag_r <= 1'b0;
    end else if (done_set) begin
      conversion_done_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      conversion_done_flag_r <= wd[CTRL_DONE];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      window_match_flag_r <= 1'b0;
    end else if (done_set && match) begin
      window_match_flag_r <= 1'b1;
    end else if (wr_ctrl) begin
      window_match_flag_r <= wd[CTRL_WIN];
    end
  end

  // analog side controls
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      track_r <= 1'b0;
      conv_r <= 1'b0;
    end else begin
      track_r <= converter_enable_r &&
                 ((state_r == ST_TRACK) ||
                  (state_r == ST_IDLE &&
                   (!track_mode_select_r ||
                    (start_source_select_r == CM_EXT &&
                     !external_start_input_i))));
      conv_r <= (state_r == ST_CONV);
    end
  end

  assign converter_power_o = converter_enable_r;
  assign track_o = track_r;
  assign convert_o = conv_r;

  // helper counters for timing checks
  logic [15:0] h_trk, h_conv;
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || state_r != ST_TRACK) begin
      h_trk <= 16'h0000;
    end else begin
      h_trk <= h_trk + 16'h0001;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (!rstn_i || state_r != ST_CONV) begin
      h_conv <= 16'h0000;
    end else begin
      h_conv <= h_conv + 16'h0001;
    end
  end

  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  chk_track_len: assert property (
    (state_r == ST_TRACK && state_nxt == ST_CONV) |->
    (h_trk == 16'(TRACK_SAR * DIV - 1)))
    else $error("tracking phase length wrong");
  chk_conv_len: assert property (
    cap |-> (h_conv == 16'(CONV_SAR * DIV - 1)))
    else $error("conversion phase length wrong");
  chk_done_busy: assert property (
    (state_r == ST_DONE) |=> (!conversion_busy_bit_r &&
                              conversion_done_flag_r))
    else $error("done flag not set as busy fell");
  chk_done_sticky: assert property (
    (conversion_done_flag_r && !wr_ctrl) |=> conversion_done_flag_r)
    else $error("done flag dropped without clear");
  chk_sw_start: assert property (
    (state_r == ST_IDLE && !start) |=> !conversion_busy_bit_r)
    else $error("busy without a start");
  chk_lp_ext: assert property (
    (start && !sw_go && track_mode_select_r &&
     start_source_select_r == CM_EXT) |=> (state_r == ST_CONV))
    else $error("external low-power start did not convert");
  chk_off_idle: assert property (
    (!converter_enable_r && !sw_go) |=> (state_r == ST_IDLE))
    else $error("disabled converter still busy");
  chk_res_fmt: assert property (
    (state_r == ST_DONE && justify_left_select_r) |->
    ({result_high_byte_r, result_low_byte_r} == {res_r, 6'h00}))
    else $error("left justified result wrong");
  chk_win_set: assert property (
    (state_r == ST_DONE && match) ##1 !wr_ctrl [*2] |->
    window_match_flag_r)
    else $error("window flag not held after match");
  chk_bus_wait: assert property (
    (wait_r && (avs_read_i || avs_write_i)) |=> !wait_r ##1 wait_r)
    else $error("bus answer not one cycle");
endmodule

// >>> tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb_top import sac_pkg::*;;
  localparam int DV = 2;
  typedef struct packed {
    logic dif;
    logic lft;
    logic [15:0] abv;
    logic [15:0] blw;
    logic [9:0] d;
    logic ex;
  } sac_wcase_t;
  localparam sac_wcase_t WC [19] = '{
    '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h041, 1'b1},
    '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h040, 1'b0},
    '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h07f, 1'b1},
    '{1'b0, 1'b0, 16'h0040, 16'h0080, 10'h080, 1'b0},
    '{1'b0, 1'b0, 16'h0040, 16'h0400, 10'h3ff, 1'b1},
    '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h03f, 1'b1},
    '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h040, 1'b0},
    '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h081, 1'b1},
    '{1'b0, 1'b0, 16'h0080, 16'h0040, 10'h080, 1'b0},
    '{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h3ff, 1'b0},
    '{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h000, 1'b1},
    '{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h03f, 1'b1},
    '{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h040, 1'b0},
    '{1'b1, 1'b0, 16'hffff, 16'h0040, 10'h200, 1'b0},
    '{1'b1, 1'b0, 16'h0040, 16'hffff, 10'h3fe, 1'b1},
    '{1'b1, 1'b0, 16'h0040, 16'hffff, 10'h3ff, 1'b0},
    '{1'b1, 1'b0, 16'h0040, 16'hffff, 10'h041, 1'b1},
    '{1'b0, 1'b1, 16'h1000, 16'h2000, 10'h041, 1'b1},
    '{1'b0, 1'b1, 16'h1000, 16'h2000, 10'h080, 1'b0}
  };
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [3:0] tmr = 4'h0;
  logic external_start_input_i = 1'b0;
  logic [9:0] sar_data_i = 10'h000;
  logic converter_power_o;
  logic track_o;
  logic convert_o;
  logic cnt_clr = 1'b1;
  int trk_n = 0;
  int cnv_n = 0;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] ix [7] = '{IDX_RES_LO, IDX_RES_HI, IDX_BLW_LO, IDX_BLW_HI,
                         IDX_CTRL, IDX_ABV_HI, 8'h10};
  logic [2:0] cms [6] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h4, 3'h6};
  int tix [6] = '{0, 2, 1, 3, 0, 0};

  sac_top #(.DIV(DV)) i_dut (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_byteenable_i(4'h1),
    .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .timer0_ovf_i(tmr[0]),
    .timer1_ovf_i(tmr[1]),
    .timer2_ovf_i(tmr[2]),
    .timer3_ovf_i(tmr[3]),
    .external_start_input_i(external_start_input_i),
    .sar_data_i(sar_data_i),
    .converter_power_o(converter_power_o),
    .track_o(track_o),
    .convert_o(convert_o)
  );

  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  // phase length counters
  always @(posedge mclk_i) begin
    if (cnt_clr) begin
      trk_n <= 0;
      cnv_n <= 0;
    end else begin
      trk_n <= trk_n + int'(track_o);
      cnv_n <= cnv_n + int'(convert_o);
    end
  end

  always @(negedge mclk_i) begin
    if (rstn_i) `CHK(track_o && convert_o, 1'b0)
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o[7:0];
    if (avs_waitrequest_o !== 1'b0) begin
      mismatches++;
      tally_and_finish;
    end
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [7:0] q);
    bus(1'b0, idx, 8'h00, q);
  endtask

  // polls control until busy drops
  task automatic wait_done(output logic [7:0] c);
    int n;
    n = 0;
    rd(IDX_CTRL, c);
    `CHK(c[CTRL_BUSY], 1'b1)
    while (c[CTRL_BUSY] !== 1'b0 && n < 40) begin
      rd(IDX_CTRL, c);
      n++;
    end
    `CHK(c[CTRL_BUSY], 1'b0)
    `CHK(c[CTRL_DONE], 1'b1)
  endtask

  task automatic clr_cnt;
    cnt_clr <= 1'b1;
    @(posedge mclk_i);
    cnt_clr <= 1'b0;
  endtask

  initial begin
    logic [7:0] q;
    logic [7:0] c;
    logic [7:0] eh;
    logic [7:0] el;
    logic [9:0] d;
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    foreach (ix[i]) begin
      rd(ix[i], q);
      `CHK(q, 8'h00)
    end
    `CHK(converter_power_o, 1'b0)
    wr(IDX_NEG, 8'(NEG_GND));
    wr(IDX_CTRL, 8'h80);
    repeat (2) @(posedge mclk_i);
    `CHK(converter_power_o, 1'b1)
    `CHK(track_o, 1'b1)
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 2; k++) begin
        d = (k == 0) ? 10'h155 : 10'h2a5;
        eh = (f == 0) ? {{6{d[9]}}, d[9:8]} : d[9:2];
        el = (f == 0) ? d[7:0] : {d[1:0], 6'h00};
        wr(IDX_CFG, (f == 0) ? 8'h00 : 8'h04);
        sar_data_i <= d;
        clr_cnt();
        wr(IDX_CTRL, 8'h90);
        wait_done(c);
        `CHK(cnv_n, 10 * DV)
        rd(IDX_RES_HI, q);
        `CHK(q, eh)
        rd(IDX_RES_LO, q);
        `CHK(q, el)
      end
    end
    rd(IDX_CTRL, c);
    `CHK(c[CTRL_DONE], 1'b1)
    wr(IDX_CTRL, 8'h80);
    rd(IDX_CTRL, c);
    `CHK(c[CTRL_DONE], 1'b0)
    wr(IDX_CTRL, 8'h91);
    repeat (30) @(posedge mclk_i);
    rd(IDX_CTRL, c);
    `CHK(c, 8'h81)
    // wrong source first, then the selected one
    foreach (cms[i]) begin
      wr(IDX_CTRL, {5'b10000, cms[i]});
      tmr <= (cms[i] >= 3'h4 && cms[i] != 3'h5) ? 4'hf : ~(4'h1 << tix[i]);
      external_start_input_i <= (cms[i] == 3'h6);
      @(posedge mclk_i);
      tmr <= 4'h0;
      repeat (30) @(posedge mclk_i);
      external_start_input_i <= 1'b0;
      rd(IDX_CTRL, c);
      `CHK(c, {5'b10000, cms[i]})
      if (cms[i] != 3'h6) begin
        if (cms[i] == CM_EXT)
          external_start_input_i <= 1'b1;
        else
          tmr <= 4'h1 << tix[i];
        @(posedge mclk_i);
        tmr <= 4'h0;
        wait_done(c);
        external_start_input_i <= 1'b0;
      end
    end
    wr(IDX_CTRL, 8'hc0);
    clr_cnt();
    wr(IDX_CTRL, 8'hd0);
    wait_done(c);
    `CHK(trk_n, 3 * DV)
    `CHK(cnv_n, 10 * DV)
    // low-power mode started by a timer overflow
    wr(IDX_CTRL, 8'hc1);
    clr_cnt();
    tmr <= 4'h1;
    @(posedge mclk_i);
    tmr <= 4'h0;
    wait_done(c);
    `CHK(trk_n, 3 * DV)
    `CHK(cnv_n, 10 * DV)
    wr(IDX_CTRL, 8'hc4);
    repeat (3) @(posedge mclk_i);
    `CHK(track_o, 1'b1)
    external_start_input_i <= 1'b1;
    @(posedge mclk_i);
    wait_done(c);
    `CHK(track_o, 1'b0)
    external_start_input_i <= 1'b0;
    wr(IDX_CTRL, 8'h80);
    foreach (WC[i]) begin
      wr(IDX_NEG, WC[i].dif ? 8'h00 : 8'(NEG_GND));
      wr(IDX_CFG, WC[i].lft ? 8'h04 : 8'h00);
      wr(IDX_ABV_LO, WC[i].abv[7:0]);
      wr(IDX_ABV_HI, WC[i].abv[15:8]);
      wr(IDX_BLW_LO, WC[i].blw[7:0]);
      wr(IDX_BLW_HI, WC[i].blw[15:8]);
      sar_data_i <= WC[i].d;
      wr(IDX_CTRL, 8'h90);
      wait_done(c);
      `CHK(c[CTRL_WIN], WC[i].ex)
      rd(IDX_CTRL, c);
      `CHK(c[CTRL_WIN], WC[i].ex)
    end
    rd(IDX_BLW_HI, q);
    `CHK(q, 8'h20)
    // disabling aborts a running conversion, no flag follows
    wr(IDX_CTRL, 8'h90);
    wr(IDX_CTRL, 8'h00);
    repeat (2) @(posedge mclk_i);
    `CHK(converter_power_o, 1'b0)
    `CHK(track_o, 1'b0)
    repeat (30) @(posedge mclk_i);
    rd(IDX_CTRL, c);
    `CHK(c, 8'h00)
    tally_and_finish;
  end

  initial begin
    repeat (90000) @(posedge mclk_i);
    mismatches++;
    tally_and_finish;
  end
endmodule
